/* File: tcc_core.sv */
// Command interpreter behind the transceiver control register
`timescale 1ns/10ps
module tcc_core #(
  parameter int unsigned STARTUP_CYC = tcc_pkg::RX_STARTUP_CYC
) (
  input  wire logic                core_clk,
  input  wire logic                nrst,
  input  wire tcc_pkg::tcc_apb_req_t apb_req,
  output tcc_pkg::tcc_apb_rsp_t    apb_rsp,
  input  wire tcc_pkg::tcc_dp_in_t dp_in,
  output tcc_pkg::tcc_dp_out_t     dp_out
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    tcc_pkg::tcc_state_t               st;
    logic [tcc_pkg::DW-1:0]            cmd;
    logic                              turn_pend;
    logic                              late;
    logic                              late_err;
    logic                              half;
    logic                              dbuf;
    logic [tcc_pkg::BUF_AW-1:0]        tx_off;
    logic [tcc_pkg::TURN_W-1:0]        turn_dly;
    logic [tcc_pkg::TIME_W-1:0]        dly_time;
    logic [tcc_pkg::TIME_W-1:0]        sys_time;
    logic [tcc_pkg::DW-1:0]            prdata;
    logic                              pslverr;
    tcc_pkg::tcc_dp_out_t              out;
  } tcc_core_t;

  tcc_core_t                   s_reg;
  tcc_core_t                   s_next;
  logic [tcc_pkg::DW-1:0]      clr;
  logic [tcc_pkg::DW-1:0]      cmd_set;
  logic [tcc_pkg::DW-1:0]      rd_data;
  logic                        hit;
  logic                        setup;
  logic                        wr;
  logic                        wr_cmd;
  logic                        late_hit;
  logic                        turn_load;
  logic                        up_load;
  logic                        turn_done;
  logic                        up_done;
  logic [tcc_pkg::TIME_W-1:0]  rx_lead;

  assign setup   = apb_req.psel && !apb_req.penable;
  assign wr      = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign wr_cmd  = wr && (apb_req.paddr == tcc_pkg::ADDR_CMD);
  // Only ones are taken; zeros leave command bits alone
  assign cmd_set = wr_cmd ? (apb_req.pwdata & tcc_pkg::CMD_MASK) : '0;
  assign rx_lead = tcc_pkg::TIME_W'(STARTUP_CYC);

  // Host write into the part already consumed
  assign late_hit = (s_reg.st == tcc_pkg::S_TX) && dp_in.hbuf_wr
                    && (dp_in.hbuf_addr >= s_reg.tx_off)
                    && (dp_in.hbuf_addr < dp_in.tx_rd_ptr);

  // ---------------------------------------------------------------------
  // Timers
  // ---------------------------------------------------------------------
  tcc_timer #(
    .W (tcc_pkg::TURN_W)
  ) u_turn_tmr (
    .core_clk (core_clk),
    .nrst     (nrst),
    .load     (turn_load),
    // Same as the abort pulse, taken from the register to keep no loop
    .clear    (s_reg.cmd[tcc_pkg::B_IDLE]),
    .value    (s_reg.turn_dly),
    .done     (turn_done),
    .busy     ()
  );

  tcc_timer #(
    .W (tcc_pkg::TURN_W)
  ) u_up_tmr (
    .core_clk (core_clk),
    .nrst     (nrst),
    .load     (up_load),
    .clear    (s_reg.cmd[tcc_pkg::B_IDLE]),
    .value    (tcc_pkg::TURN_W'(STARTUP_CYC)),
    .done     (up_done),
    .busy     ()
  );

  // ---------------------------------------------------------------------
  // Register read mux
  // ---------------------------------------------------------------------
  always_comb begin
    hit     = 1'b1;
    rd_data = tcc_pkg::RST_WORD;
    unique case (apb_req.paddr)
      tcc_pkg::ADDR_SYSTIME: rd_data = s_reg.sys_time;
      tcc_pkg::ADDR_TXCFG: begin
        rd_data[tcc_pkg::BUF_AW-1:0] = s_reg.tx_off;
        rd_data[tcc_pkg::CFG_DBUF]   = s_reg.dbuf;
      end
      tcc_pkg::ADDR_DLYTIME: rd_data = s_reg.dly_time;
      tcc_pkg::ADDR_CMD:     rd_data = s_reg.cmd;
      tcc_pkg::ADDR_STATUS: begin
        rd_data[2:0]              = 3'(s_reg.st);
        rd_data[tcc_pkg::ST_LATE] = s_reg.late_err;
        // Host-side receive half
        rd_data[tcc_pkg::ST_HALF] = s_reg.half;
      end
      tcc_pkg::ADDR_TURN: rd_data[tcc_pkg::TURN_W-1:0] = s_reg.turn_dly;
      default: hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    s_next              = s_reg;
    s_next.out.tx_go    = 1'b0;
    s_next.out.abort    = 1'b0;
    s_next.sys_time     = s_reg.sys_time + tcc_pkg::TIME_W'(1);
    clr                 = '0;
    turn_load           = 1'b0;
    up_load             = 1'b0;

    if (setup) begin
      s_next.prdata  = hit ? rd_data : tcc_pkg::RST_WORD;
      s_next.pslverr = !hit;
    end
    if (wr) begin
      unique case (apb_req.paddr)
        tcc_pkg::ADDR_TXCFG: begin
          s_next.tx_off = apb_req.pwdata[tcc_pkg::BUF_AW-1:0];
          s_next.dbuf   = apb_req.pwdata[tcc_pkg::CFG_DBUF];
        end
        tcc_pkg::ADDR_DLYTIME: s_next.dly_time = apb_req.pwdata;
        tcc_pkg::ADDR_TURN:
          s_next.turn_dly = apb_req.pwdata[tcc_pkg::TURN_W-1:0];
        tcc_pkg::ADDR_STATUS:
          if (apb_req.pwdata[tcc_pkg::ST_LATE]) begin
            s_next.late_err = 1'b0;
          end
        tcc_pkg::ADDR_CMD:
          if (apb_req.pwdata[tcc_pkg::B_TOGGLE] && s_reg.dbuf) begin
            s_next.half = !s_reg.half;
          end
        default: ;
      endcase
    end

    if (s_reg.cmd[tcc_pkg::B_IDLE]) begin
      // Abort wins over every state; pending commands are dropped too
      s_next.st         = tcc_pkg::S_IDLE;
      s_next.out.abort  = 1'b1;
      s_next.turn_pend  = 1'b0;
      s_next.late       = 1'b0;
      clr               = tcc_pkg::CMD_MASK;
    end else begin
      unique case (s_reg.st)
        tcc_pkg::S_IDLE:
          if (s_reg.cmd[tcc_pkg::B_TXSTART]) begin
            if (s_reg.cmd[tcc_pkg::B_DLYSEND]) begin
              s_next.st = tcc_pkg::S_TXDLY;
            end else begin
              s_next.st                = tcc_pkg::S_TX;
              s_next.out.tx_go         = 1'b1;
              s_next.out.fcs_from_buf  = s_reg.cmd[tcc_pkg::B_SUPPRESS];
              s_next.out.fcs_bad       = 1'b0;
              s_next.late              = 1'b0;
              s_next.turn_pend         = s_reg.cmd[tcc_pkg::B_TURN];
              clr[tcc_pkg::B_TXSTART]  = 1'b1;
              clr[tcc_pkg::B_SUPPRESS] = 1'b1;
            end
          end else if (s_reg.cmd[tcc_pkg::B_RXEN]) begin
            if (s_reg.cmd[tcc_pkg::B_DLYRX]) begin
              s_next.st = tcc_pkg::S_RXDLY;
            end else begin
              s_next.st            = tcc_pkg::S_RXUP;
              up_load              = 1'b1;
              clr[tcc_pkg::B_RXEN] = 1'b1;
            end
          end
        tcc_pkg::S_TXDLY:
          if (s_reg.sys_time == s_reg.dly_time) begin
            s_next.st                = tcc_pkg::S_TX;
            s_next.out.tx_go         = 1'b1;
            s_next.out.fcs_from_buf  = s_reg.cmd[tcc_pkg::B_SUPPRESS];
            s_next.out.fcs_bad       = 1'b0;
            s_next.late              = 1'b0;
            s_next.turn_pend         = s_reg.cmd[tcc_pkg::B_TURN];
            clr[tcc_pkg::B_TXSTART]  = 1'b1;
            clr[tcc_pkg::B_DLYSEND]  = 1'b1;
            clr[tcc_pkg::B_SUPPRESS] = 1'b1;
          end
        tcc_pkg::S_TX: begin
          if (late_hit) begin
            // Checksum stays suppressed: the far end sees a bad frame
            s_next.late               = 1'b1;
            s_next.out.fcs_bad        = 1'b1;
            s_next.out.fcs_from_buf   = 1'b1;
          end else if (s_reg.cmd[tcc_pkg::B_CANCEL] && !s_reg.late) begin
            s_next.out.fcs_from_buf = 1'b0;
          end
          clr[tcc_pkg::B_CANCEL] = s_reg.cmd[tcc_pkg::B_CANCEL];
          if (dp_in.tx_done) begin
            if (s_reg.turn_pend) begin
              s_next.st = tcc_pkg::S_TURN;
              turn_load = 1'b1;
            end else begin
              s_next.st = tcc_pkg::S_IDLE;
            end
            s_next.turn_pend = 1'b0;
          end
        end
        tcc_pkg::S_TURN:
          if (turn_done) begin
            s_next.st            = tcc_pkg::S_RXUP;
            up_load              = 1'b1;
            clr[tcc_pkg::B_TURN] = 1'b1;
          end
        tcc_pkg::S_RXDLY:
          // Turn on early by the start-up latency to hit the time
          if (s_reg.sys_time + rx_lead == s_reg.dly_time) begin
            s_next.st             = tcc_pkg::S_RXUP;
            up_load               = 1'b1;
            clr[tcc_pkg::B_RXEN]  = 1'b1;
            clr[tcc_pkg::B_DLYRX] = 1'b1;
          end
        tcc_pkg::S_RXUP:
          if (up_done) begin
            s_next.st = tcc_pkg::S_RX;
          end
        tcc_pkg::S_RX:
          if (dp_in.rx_done) begin
            s_next.st = tcc_pkg::S_IDLE;
          end
        default: s_next.st = tcc_pkg::S_IDLE;
      endcase
    end

    // New ones written this cycle win over a clear
    s_next.cmd = (s_reg.cmd & ~clr) | cmd_set;
    if (late_hit) begin
      s_next.late_err = 1'b1;
    end
    s_next.out.rx_on     = (s_next.st == tcc_pkg::S_RXUP)
                           || (s_next.st == tcc_pkg::S_RX);
    s_next.out.rx_search = (s_next.st == tcc_pkg::S_RX);
    s_next.out.rx_half   = s_next.half;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_reg    <= '0;
      s_reg.st <= tcc_pkg::S_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.prdata  = s_reg.prdata;
  assign apb_rsp.pslverr = s_reg.pslverr;
  assign dp_out          = s_reg.out;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  // Cycles spent in the current state
  logic [23:0] dwell;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dwell <= 24'h00_0001;
    end else if (s_next.st != s_reg.st) begin
      dwell <= 24'h00_0001;
    end else begin
      dwell <= dwell + 24'h00_0001;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence seq_tx_ends_turn;
    s_reg.st == tcc_pkg::S_TX && dp_in.tx_done && s_reg.turn_pend
    && !s_reg.cmd[tcc_pkg::B_IDLE];
  endsequence

  sequence seq_cancel_ok;
    s_reg.st == tcc_pkg::S_TX && s_reg.cmd[tcc_pkg::B_CANCEL]
    && !s_reg.late && !late_hit && !s_reg.cmd[tcc_pkg::B_IDLE];
  endsequence

  a_start_clears: assert property (
    dp_out.tx_go |-> !s_reg.cmd[tcc_pkg::B_TXSTART]
                     || $past(wr_cmd))
    else $error("start bit still set after transmit began");

  a_fcs_source: assert property (
    $rose(dp_out.tx_go) |-> dp_out.fcs_from_buf
                           == $past(s_reg.cmd[tcc_pkg::B_SUPPRESS]))
    else $error("checksum source differs from suppress bit");

  a_cancel_applies: assert property (
    seq_cancel_ok |=> !dp_out.fcs_from_buf)
    else $error("valid cancel did not enable generated checksum");

  a_late_flags: assert property (
    late_hit && !s_reg.cmd[tcc_pkg::B_IDLE]
    |=> dp_out.fcs_bad && dp_out.fcs_from_buf && s_reg.late_err)
    else $error("late buffer write not flagged");

  a_cancel_clears: assert property (
    (seq_cancel_ok and !wr_cmd) |=> !s_reg.cmd[tcc_pkg::B_CANCEL])
    else $error("cancel bit did not self-clear");

  a_idle_abort: assert property (
    s_reg.cmd[tcc_pkg::B_IDLE] && !wr_cmd
    |=> s_reg.st == tcc_pkg::S_IDLE && dp_out.abort
        && !s_reg.cmd[tcc_pkg::B_IDLE] && !s_reg.cmd[tcc_pkg::B_TURN])
    else $error("force idle did not abort and clear");

  a_turn_enter: assert property (
    seq_tx_ends_turn |=> s_reg.st == tcc_pkg::S_TURN && !dp_out.rx_on)
    else $error("no turnaround after frame end");

  a_turn_delay: assert property (
    s_reg.st == tcc_pkg::S_TURN && s_next.st == tcc_pkg::S_RXUP
    |-> dwell == ((s_reg.turn_dly == '0) ? 24'h00_0001
                  : 24'(s_reg.turn_dly)))
    else $error("turnaround delay length wrong");

  a_rx_startup: assert property (
    s_reg.st == tcc_pkg::S_RXUP && s_next.st == tcc_pkg::S_RX
    |-> dwell == 24'(STARTUP_CYC) ##1 dp_out.rx_search)
    else $error("receiver start-up latency wrong");

  a_half_toggle: assert property (
    wr_cmd && apb_req.pwdata[tcc_pkg::B_TOGGLE] && s_reg.dbuf
    |=> dp_out.rx_half != $past(s_reg.half))
    else $error("receive half did not toggle");

endmodule

/* File: tcc_pkg.sv */
// Constants and carrier types of the transceiver command control block
package tcc_pkg;

  // ---------------------------------------------------------------------
  // Summary of operation
  // ---------------------------------------------------------------------

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned RX_STARTUP_NS  = 16_000;
  localparam int unsigned RX_STARTUP_CYC =
    (RX_STARTUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // ---------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------
  localparam int unsigned AW     = 12;
  localparam int unsigned DW     = 32;
  localparam int unsigned BUF_AW = 10;
  localparam int unsigned TURN_W = 20;
  localparam int unsigned TIME_W = 32;

  // ---------------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ---------------------------------------------------------------------
  localparam logic [9:0] IDX_SYSTIME = 10'h006;
  localparam logic [9:0] IDX_TXCFG   = 10'h008;
  localparam logic [9:0] IDX_DLYTIME = 10'h00A;
  localparam logic [9:0] IDX_CMD     = 10'h00D;
  localparam logic [9:0] IDX_STATUS  = 10'h00F;
  localparam logic [9:0] IDX_TURN    = 10'h01A;
  localparam logic [AW-1:0] ADDR_SYSTIME = {IDX_SYSTIME, 2'b00};
  localparam logic [AW-1:0] ADDR_TXCFG   = {IDX_TXCFG, 2'b00};
  localparam logic [AW-1:0] ADDR_DLYTIME = {IDX_DLYTIME, 2'b00};
  localparam logic [AW-1:0] ADDR_CMD     = {IDX_CMD, 2'b00};
  localparam logic [AW-1:0] ADDR_STATUS  = {IDX_STATUS, 2'b00};
  localparam logic [AW-1:0] ADDR_TURN    = {IDX_TURN, 2'b00};

  // ---------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------
  localparam int unsigned B_SUPPRESS = 0;
  localparam int unsigned B_TXSTART  = 1;
  localparam int unsigned B_DLYSEND  = 2;
  localparam int unsigned B_CANCEL   = 3;
  localparam int unsigned B_IDLE     = 6;
  localparam int unsigned B_TURN     = 7;
  localparam int unsigned B_RXEN     = 8;
  localparam int unsigned B_DLYRX    = 9;
  localparam int unsigned B_TOGGLE   = 24;
  localparam logic [DW-1:0] CMD_MASK = 32'h0000_03CF;
  localparam int unsigned CFG_DBUF   = 16;
  localparam int unsigned ST_LATE    = 28;
  localparam int unsigned ST_HALF    = 31;
  localparam logic [DW-1:0] RST_WORD = 32'h0000_0000;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_TXDLY, S_TX, S_TURN, S_RXDLY, S_RXUP, S_RX
  } tcc_state_t;

  typedef struct packed {
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [AW-1:0] paddr;
    logic [DW-1:0] pwdata;
  } tcc_apb_req_t;

  typedef struct packed {
    logic          pready;
    logic [DW-1:0] prdata;
    logic          pslverr;
  } tcc_apb_rsp_t;

  typedef struct packed {
    logic              tx_done;
    logic              rx_done;
    logic [BUF_AW-1:0] tx_rd_ptr;
    logic              hbuf_wr;
    logic [BUF_AW-1:0] hbuf_addr;
  } tcc_dp_in_t;

  typedef struct packed {
    logic tx_go;
    logic fcs_from_buf;
    logic fcs_bad;
    logic abort;
    logic rx_on;
    logic rx_search;
    logic rx_half;
  } tcc_dp_out_t;

endpackage

/* File: tcc_timer.sv */
// Reloadable down-counter giving a one-cycle done pulse
`timescale 1ns/10ps
module tcc_timer #(
  parameter int unsigned W = 20
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic         load,
  input  wire logic         clear,
  input  wire logic [W-1:0] value,
  output logic              done,
  output logic              busy
);

  typedef struct packed {
    logic         run;
    logic [W-1:0] cnt;
  } tcc_tmr_t;

  tcc_tmr_t s_reg;
  tcc_tmr_t s_next;

  always_comb begin
    s_next = s_reg;
    if (clear) begin
      s_next = '0;
    end else if (load) begin
      s_next.run = 1'b1;
      // A zero load still takes one cycle
      s_next.cnt = (value == '0) ? W'(1) : value;
    end else if (s_reg.run) begin
      if (s_reg.cnt == W'(1)) begin
        s_next = '0;
      end else begin
        s_next.cnt = s_reg.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign done = s_reg.run && (s_reg.cnt == W'(1)) && !clear;
  assign busy = s_reg.run;

endmodule

/* File: tcc_dp_model.sv */
// Datapath stand-in: frame timing, read pointer and end of reception
`timescale 1ns/10ps
module tcc_dp_model #(
  parameter int unsigned FLEN  = 40,
  parameter int unsigned RXLEN = 30
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       tx_go,
  input  wire logic       abort,
  input  wire logic       rx_search,
  output logic            tx_done,
  output logic            rx_done,
  output logic [9:0]      tx_rd_ptr
);
  int unsigned left;
  int unsigned rxc;

  // ---------------------------------------------------------------
  // Frame and reception timing
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_done   <= 1'b0;
      rx_done   <= 1'b0;
      tx_rd_ptr <= 10'h000;
      left      <= 0;
      rxc       <= 0;
    end else begin
      tx_done <= 1'b0;
      rx_done <= rx_search && (rxc == RXLEN - 1);
      rxc     <= (rx_search && !abort && rxc < RXLEN) ? rxc + 1 : 0;
      if (abort) begin
        left <= 0;
      end else if (tx_go) begin
        left      <= FLEN;
        tx_rd_ptr <= 10'h000;
      end else if (left != 0) begin
        left      <= left - 1;
        tx_rd_ptr <= tx_rd_ptr + 10'h001;
        tx_done   <= (left == 1);
      end
    end
  end
endmodule

/* File: tb_transceiver_command_control.sv */
// Self-checking bench for the transceiver command interpreter
`timescale 1ns/10ps
module tb_transceiver_command_control;
  localparam int SU = 8;
  localparam int TD = 6;
  localparam logic [11:0] A_CMD = tcc_pkg::ADDR_CMD;
  localparam logic [11:0] A_ST  = tcc_pkg::ADDR_STATUS;
  localparam logic [11:0] A_CFG = tcc_pkg::ADDR_TXCFG;
  logic                  core_clk;
  logic                  nrst;
  tcc_pkg::tcc_apb_req_t req;
  tcc_pkg::tcc_apb_rsp_t rsp;
  tcc_pkg::tcc_dp_in_t   dpi;
  tcc_pkg::tcc_dp_out_t  dpo;
  logic                  tx_done;
  logic                  rx_done;
  logic [9:0]            rd_ptr;
  logic                  hw;
  logic [9:0]            ha;
  logic [7:0]            mon;
  logic [31:0]           r;
  logic                  e;
  logic                  hit;
  int                    num_errors;
  int                    tests_run;
  int                    cyc = 0;
  int                    t0;
  int                    t;
  int                    n;

  assign dpi = {tx_done, rx_done, rd_ptr, hw, ha};
  // Bits: 7 go, 6 buf, 5 bad, 4 abort, 3 on, 2 search, 1 half, 0 done
  assign mon = {dpo, tx_done};

  tcc_core #(.STARTUP_CYC(SU)) i_dut (
    .core_clk (core_clk),
    .nrst     (nrst),
    .apb_req  (req),
    .apb_rsp  (rsp),
    .dp_in    (dpi),
    .dp_out   (dpo)
  );

  tcc_dp_model i_dp (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .tx_go     (dpo.tx_go),
    .abort     (dpo.abort),
    .rx_search (dpo.rx_search),
    .tx_done   (tx_done),
    .rx_done   (rx_done),
    .tx_rd_ptr (rd_ptr)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk) cyc <= cyc + 1;

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, y);
    tests_run++;
    if (y !== x) begin
      $display("MISMATCH %s expected %h seen %h", nm, x, y);
      num_errors++;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge core_clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    t0 = cyc;
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      chk("pready", 1, 0);
      complete_run();
    end
    r = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask

  // Level wait on a watched bit; n counts falling edges
  task automatic wt(input int b, input logic v);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (mon[b] !== v && n < 400);
    if (n >= 400) begin
      chk("wait", 1, 0);
      complete_run();
    end
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    req = '0;
    hw = 1'b0;
    ha = 10'h000;
    num_errors = 0;
    tests_run = 0;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    apb(0, A_CMD, 0);
    chk("cmd_reset", 0, r);
    apb(0, 12'hFFC, 0);
    chk("unmapped", 1, e);
    apb(1, A_CMD, 0);
    hit = 1'b0;
    repeat (10) begin
      @(negedge core_clk);
      hit = hit | mon[7] | mon[3];
    end
    chk("zero_write", 0, hit);
    $display("test reset and zero write done");
    apb(1, A_CFG, 32'h0001_0000);
    apb(1, A_CMD, 32'h0100_0000);
    repeat (2) @(negedge core_clk);
    chk("half_on", 1, dpo.rx_half);
    apb(0, A_ST, 0);
    chk("half_stat", 1, r[31]);
    apb(1, A_CFG, 0);
    apb(1, A_CMD, 32'h0100_0000);
    repeat (2) @(negedge core_clk);
    chk("half_held", 1, dpo.rx_half);
    $display("test toggle done");
    apb(1, A_CMD, 32'h3);
    wt(7, 1);
    chk("fcs_buf", 1, dpo.fcs_from_buf);
    apb(0, A_CMD, 0);
    chk("start_clr", 0, r[1:0]);
    @(posedge core_clk);
    hw <= 1'b1;
    ha <= 10'h001;
    @(posedge core_clk);
    hw <= 1'b0;
    @(negedge core_clk);
    chk("late_bad", 1, dpo.fcs_bad);
    apb(0, A_ST, 0);
    chk("late_flag", 1, r[28]);
    apb(1, A_CMD, 32'h8);
    apb(0, A_CMD, 0);
    chk("cancel_clr", 0, r[3]);
    chk("cancel_void", 1, dpo.fcs_bad);
    wt(0, 1);
    apb(1, A_ST, 32'h1000_0000);
    apb(0, A_ST, 0);
    chk("late_w1c", 0, r[28]);
    apb(1, A_CMD, 32'h3);
    wt(7, 1);
    apb(1, A_CMD, 32'h8);
    repeat (2) @(negedge core_clk);
    chk("cancel_ok", 0, dpo.fcs_from_buf);
    chk("no_bad", 0, dpo.fcs_bad);
    wt(0, 1);
    $display("test checksum done");
    apb(1, tcc_pkg::ADDR_TURN, TD);
    apb(1, A_CMD, 32'h82);
    wt(0, 1);
    wt(3, 1);
    chk("turn_gap", 1, n >= TD && n <= TD + 2);
    wt(2, 1);
    chk("turn_up", 1, n >= SU && n <= SU + 1);
    apb(0, A_CMD, 0);
    chk("turn_clr", 0, r[7]);
    apb(1, A_CMD, 32'h40);
    wt(4, 1);
    chk("rx_abort", 0, dpo.rx_on);
    apb(0, A_CMD, 0);
    chk("idle_clr", 0, r);
    $display("test turnaround done");
    apb(1, A_CMD, 32'h100);
    wt(3, 1);
    wt(2, 1);
    chk("rx_startup", SU, n);
    apb(0, A_CMD, 0);
    chk("rxen_clr", 0, r[8]);
    wt(2, 0);
    apb(1, A_CMD, 32'h2);
    wt(7, 1);
    apb(1, A_CMD, 32'h40);
    wt(4, 1);
    apb(0, A_ST, 0);
    chk("tx_abort", 0, r[2:0]);
    $display("test receive and abort done");
    apb(0, tcc_pkg::ADDR_SYSTIME, 0);
    t = t0;
    apb(1, tcc_pkg::ADDR_DLYTIME, r + 60);
    apb(1, A_CMD, 32'h6);
    apb(0, A_ST, 0);
    chk("dly_wait", 1, r[2:0]);
    wt(7, 1);
    chk("dly_send", 1, cyc - t >= 59 && cyc - t <= 63);
    wt(0, 1);
    apb(0, tcc_pkg::ADDR_SYSTIME, 0);
    t = t0;
    apb(1, tcc_pkg::ADDR_DLYTIME, r + 80);
    apb(1, A_CMD, 32'h300);
    wt(3, 1);
    chk("dly_on", 1, cyc - t >= 70 && cyc - t <= 75);
    wt(2, 1);
    chk("dly_srch", 1, cyc - t >= 79 && cyc - t <= 84);
    $display("test delayed done");
    complete_run();
  end
endmodule
